// ### verilog/port_power_fault_sequencer.sv
// Four-channel port power sequencer: relay and gate sequencing,
// current-limit and open-circuit faults, retry duty cycle, fault pin.
// Assumes comparator inputs synchronous to CLOCK, APB master outside.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module port_power_fault_sequencer #(
  parameter int unsigned TON_CYC = `TURN_ON_DELAY_MS * `CLK_KHZ,
  parameter int unsigned FILT_CYC = `UNDERCUR_FILTER_MS * `CLK_KHZ,
  parameter int unsigned LIMIT_BASE_CYC = `LIMIT_BASE_MS * `CLK_KHZ,
  parameter int unsigned GUARD_BASE_CYC = `GUARD_BASE_MS * `CLK_KHZ
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [4:0] ADDR_STRAP,
  input wire logic [3:0] PGOOD_IN,
  input wire logic [3:0] ILIM_IN,
  input wire logic [3:0] UNDERCUR_IN,
  output logic [3:0] RELAY_DRIVE,
  output logic [3:0] GATE_DRIVE,
  output logic FAULT_N_O,
  output logic FAULT_N_OE,
  output logic [6:0] DEV_ADDR
);
  pfs_pkg::seq_state_t r_r, r_nxt;
  logic [7:0] ctrl_act;
  logic [7:0] setup_bits;
  logic fault_clr;
  logic [3:0] en_w;
  logic autoretry;
  logic open_en;
  logic duty_hi;
  logic [1:0] lim_sel;
  logic [1:0] grd_sel;
  logic [31:0] lim_len;
  logic [31:0] grd_len;
  logic [31:0] rty_len;
  logic [31:0] ton_last;
  logic [31:0] filt_last;
  logic [3:0] set_s;
  logic [3:0] set_o;

  // Register slave
  pfs_apb_regs u_regs (
    .clk(CLOCK),
    .rst_n(RST_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .ctrl_act(ctrl_act),
    .setup_bits(setup_bits),
    .fault_clr(fault_clr),
    .pg(r_r.pg),
    .shorted(r_r.shorted),
    .opened(r_r.opened),
    .dev_addr(r_r.addr)
  );

  // Per-channel enables from the control fields; setup fields, shared by all four channels
  assign en_w = ctrl_act[`CTL_SW_LSB +: `NCH] &
                ctrl_act[`CTL_RLY_LSB +: `NCH];
  assign autoretry = setup_bits[`SU_AUTORETRY];
  assign open_en = setup_bits[`SU_OPEN_EN];
  assign duty_hi = setup_bits[`SU_DUTY];
  assign lim_sel = setup_bits[`SU_LIM_LSB +: `SEL_W];
  assign grd_sel = setup_bits[`SU_GRD_LSB +: `SEL_W];

  // Selected timer lengths; each select step doubles the time
  assign lim_len = 32'(LIMIT_BASE_CYC) << lim_sel;
  assign grd_len = 32'(GUARD_BASE_CYC) << grd_sel;
  assign ton_last = 32'(TON_CYC) - `CNT_ONE;
  assign filt_last = 32'(FILT_CYC) - `CNT_ONE;

  // Off-time over on-time sets the retry duty; 50/3 gives 6 percent,
  // 120 gives 0.83 percent of the limit time spent on
  assign rty_len = duty_hi ?
                   32'(lim_len * `DUTY_HI_NUM / `DUTY_HI_DEN) :
                   32'(lim_len * `DUTY_LO_NUM / `DUTY_LO_DEN);

  // Next state of all four channel sequencers
  always_comb begin
    r_nxt = r_r;
    set_s = '0;
    set_o = '0;
    // Straps are re-sampled every cycle, never under reset
    r_nxt.addr = {`ADDR_FIXED, ADDR_STRAP};
    for (int i = 0; i < `NCH; i++) begin
      // Retry timer runs down whatever the channel does
      if (r_r.rty[i] != `CNT_ZERO) begin
        r_nxt.rty[i] = r_r.rty[i] - `CNT_ONE;
      end
      unique case (r_r.st[i])
        pfs_pkg::CH_OFF: begin
          // Open faults block restart until cleared
          // Shorts block unless autoretry
          if (en_w[i] && !r_r.opened[i] &&
              r_r.rty[i] == `CNT_ZERO &&
              (!r_r.shorted[i] || autoretry)) begin
            r_nxt.st[i] = pfs_pkg::CH_DELAY;
          end
        end
        pfs_pkg::CH_DELAY: begin
          // Relay on, gate waits out the turn-on delay
          if (!en_w[i]) begin
            r_nxt.st[i] = pfs_pkg::CH_OFF;
          end else if (r_r.tmr[i] == ton_last) begin
            r_nxt.st[i] = pfs_pkg::CH_GATE;
            r_nxt.tmr[i] = `CNT_ZERO;
          end else begin
            r_nxt.tmr[i] = r_r.tmr[i] + `CNT_ONE;
          end
        end
        pfs_pkg::CH_GATE: begin
          if (!en_w[i]) begin
            r_nxt.st[i] = pfs_pkg::CH_OFF;
          end else begin
            // Power-good latches and starts the guard timer
            if (PGOOD_IN[i] && !r_r.pg[i]) begin
              r_nxt.pg[i] = 1'b1;
              r_nxt.tmr[i] = `CNT_ZERO;
            end else if (r_r.pg[i] && !r_r.armed[i]) begin
              if (r_r.tmr[i] == grd_len - `CNT_ONE) begin
                r_nxt.armed[i] = 1'b1;
              end else begin
                r_nxt.tmr[i] = r_r.tmr[i] + `CNT_ONE;
              end
            end
            // Open filter only counts while armed and enabled
            if (r_r.armed[i] && open_en && UNDERCUR_IN[i]) begin
              if (r_r.ocf[i] == filt_last) begin
                set_o[i] = 1'b1;
              end else begin
                r_nxt.ocf[i] = r_r.ocf[i] + `CNT_ONE;
              end
            end else begin
              r_nxt.ocf[i] = `CNT_ZERO;
            end
            // Limit timer restarts whenever the limit releases
            if (ILIM_IN[i]) begin
              if (r_r.lim[i] == lim_len - `CNT_ONE) begin
                set_s[i] = 1'b1;
              end else begin
                r_nxt.lim[i] = r_r.lim[i] + `CNT_ONE;
              end
            end else begin
              r_nxt.lim[i] = `CNT_ZERO;
            end
            // A short wins over an open trip in the same cycle
            if (set_s[i]) begin
              set_o[i] = 1'b0;
              r_nxt.rty[i] = rty_len;
            end
            if (set_s[i] || set_o[i]) begin
              r_nxt.st[i] = pfs_pkg::CH_OFF;
            end
          end
        end
      endcase
      // Off means no power-good and idle timers, all but the retry timer
      if (r_nxt.st[i] == pfs_pkg::CH_OFF) begin
        r_nxt.pg[i] = 1'b0;
        r_nxt.armed[i] = 1'b0;
        r_nxt.tmr[i] = `CNT_ZERO;
        r_nxt.lim[i] = `CNT_ZERO;
        r_nxt.ocf[i] = `CNT_ZERO;
      end
      r_nxt.relay[i] = r_nxt.st[i] != pfs_pkg::CH_OFF;
      r_nxt.gate[i] = r_nxt.st[i] == pfs_pkg::CH_GATE;
      // A new fault beats a clear in the same cycle
      r_nxt.shorted[i] = (r_r.shorted[i] & ~fault_clr) | set_s[i];
      r_nxt.opened[i] = (r_r.opened[i] & ~fault_clr) | set_o[i];
    end
    // Pin is the OR of all eight flags
    r_nxt.fault = |{r_nxt.shorted, r_nxt.opened};
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops; fault pin is open drain, low when on
  assign RELAY_DRIVE = r_r.relay;
  assign GATE_DRIVE = r_r.gate;
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE = r_r.fault;
  assign DEV_ADDR = r_r.addr;

  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // Per-channel checks
  for (genvar g = 0; g < `NCH; g++) begin : g_chk
    a_gate_after_delay: assert property (
      $rose(GATE_DRIVE[g]) |->
        $past(r_r.tmr[g]) == ton_last && RELAY_DRIVE[g] &&
        $past(RELAY_DRIVE[g]))
      else $error("Gate rose before the turn-on delay");
    a_limit_trip: assert property (
      (r_r.st[g] == pfs_pkg::CH_GATE && en_w[g] && ILIM_IN[g] &&
       r_r.lim[g] == lim_len - `CNT_ONE) |=>
        r_r.shorted[g] && !GATE_DRIVE[g] && FAULT_N_OE &&
        r_r.rty[g] == $past(rty_len))
      else $error("Limit expiry did not trip the channel");
    a_open_trip: assert property (
      (r_r.st[g] == pfs_pkg::CH_GATE && en_w[g] && !ILIM_IN[g] &&
       r_r.armed[g] && open_en && UNDERCUR_IN[g] &&
       r_r.ocf[g] == filt_last) |=>
        r_r.opened[g] && !GATE_DRIVE[g] && !RELAY_DRIVE[g])
      else $error("Undercurrent filter expiry did not trip");
    a_open_stays_off: assert property (
      r_r.opened[g] |-> !RELAY_DRIVE[g] && !GATE_DRIVE[g])
      else $error("Channel powered while open fault set");
    a_retry_holds: assert property (
      r_r.rty[g] != `CNT_ZERO |-> !RELAY_DRIVE[g])
      else $error("Channel powered during retry time");
    a_latch_off: assert property (
      (r_r.shorted[g] && !autoretry) |=> !$rose(RELAY_DRIVE[g]))
      else $error("Shorted channel restarted without autoretry");
    a_pg_needs_gate: assert property (
      !GATE_DRIVE[g] |-> !r_r.pg[g] && r_r.lim[g] == `CNT_ZERO)
      else $error("Power-good or limit timer kept while off");
    c_auto_restart: cover property (
      $rose(RELAY_DRIVE[g]) && r_r.shorted[g]);
    a_gate_has_relay: assert property (
      GATE_DRIVE[g] |-> RELAY_DRIVE[g])
      else $error("Gate driven without the relay");
    // Guard, restart and turn-off sequencing
    a_pg_sets: assert property (
      (r_r.st[g] == pfs_pkg::CH_GATE && en_w[g] && PGOOD_IN[g] &&
       !r_r.pg[g] && !set_s[g]) |=>
        r_r.pg[g] && r_r.tmr[g] == `CNT_ZERO)
      else $error("Power-good did not latch or start the guard");
    a_arm_after_guard: assert property (
      (r_r.st[g] == pfs_pkg::CH_GATE && en_w[g] && r_r.pg[g] &&
       !r_r.armed[g] && r_r.tmr[g] == grd_len - `CNT_ONE &&
       !set_s[g]) |=> r_r.armed[g])
      else $error("Open detection not armed at guard expiry");
    a_auto_restart: assert property (
      (r_r.st[g] == pfs_pkg::CH_OFF && en_w[g] && autoretry &&
       r_r.shorted[g] && !r_r.opened[g] && r_r.rty[g] == `CNT_ZERO) |=>
        RELAY_DRIVE[g])
      else $error("Autoretry did not restart the channel");
    a_off_on_disable: assert property (
      !en_w[g] |=> !RELAY_DRIVE[g] && !GATE_DRIVE[g])
      else $error("Channel stayed on after its enables dropped");
  end

  // Whole-block checks
  a_clear_release: assert property (
    (fault_clr && set_s == '0 && set_o == '0) |=>
      !FAULT_N_OE && r_r.opened == '0 && r_r.shorted == '0)
    else $error("Fault clear did not release the pin");
  a_addr_form: assert property (
    1'b1 |=> DEV_ADDR == {`ADDR_FIXED, $past(ADDR_STRAP)})
    else $error("Device address not formed from straps");
  c_short_trip: cover property ($rose(|r_r.shorted));
  c_open_trip: cover property ($rose(|r_r.opened));
  c_clear_in_retry: cover property (fault_clr && r_r.rty != '0);
endmodule
`default_nettype wire

// ### verilog/pfs_map.svh
// Register offsets, field positions, reset values and timing figures
// for the four-channel port power sequencer.
// Assumes a 40 MHz CLOCK and a 12-bit APB byte address.
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_SETUP 12'h004
`define OFS_STATUS1 12'h008
`define OFS_STATUS2 12'h00C
`define OFS_COMMIT 12'h010
`define OFS_ADDRESS 12'h014
// Reset values
`define CTRL_RST 8'h00
`define SETUP_RST 8'h00
`define RDATA_RST 32'h0000_0000
// Channel count and field layout
`define NCH 4
`define SEL_W 2
`define CTL_SW_LSB 0
`define CTL_RLY_LSB 4
`define SU_CLEAR 0
`define SU_AUTORETRY 1
`define SU_OPEN_EN 2
`define SU_DUTY 3
`define SU_LIM_LSB 4
`define SU_GRD_LSB 6
// Clear bit is a strobe and is never stored
`define SU_STORE_MASK 8'hFE
// Status 1 upper nibble: bit 4 reads high, 7:5 low
`define STATUS1_RSVD 4'h1
// Serial address bits 6:5 (bit 6 low, bit 5 high)
`define ADDR_FIXED 2'h1
// Timing figures in their own units
`define CLK_KHZ 40000
`define TURN_ON_DELAY_MS 18
`define UNDERCUR_FILTER_MS 18
`define LIMIT_BASE_MS 1
`define GUARD_BASE_MS 50
// Retry off-time as a multiple of the limit time (num/den)
`define DUTY_HI_NUM 32'h0000_0032
`define DUTY_HI_DEN 32'h0000_0003
`define DUTY_LO_NUM 32'h0000_0078
`define DUTY_LO_DEN 32'h0000_0001
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`endif

// ### verilog/pfs_pkg.sv
// Types shared by the port sequencer and its register slave.
// Assumes pfs_map.svh is on the include path.
`default_nettype none
`include "pfs_map.svh"
package pfs_pkg;
  typedef enum logic [1:0] {CH_OFF, CH_DELAY, CH_GATE} chan_st_t;

  // Whole sequencer state, one slice per channel
  typedef struct packed {
    chan_st_t [`NCH-1:0] st;
    logic [`NCH-1:0][31:0] tmr;
    logic [`NCH-1:0][31:0] lim;
    logic [`NCH-1:0][31:0] ocf;
    logic [`NCH-1:0][31:0] rty;
    logic [`NCH-1:0] pg;
    logic [`NCH-1:0] armed;
    logic [`NCH-1:0] shorted;
    logic [`NCH-1:0] opened;
    logic [`NCH-1:0] relay;
    logic [`NCH-1:0] gate;
    logic fault;
    logic [6:0] addr;
  } seq_state_t;

  // Register slave state
  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] act;
    logic [7:0] setup;
    logic [31:0] rdata;
    logic err;
  } regs_state_t;
endpackage
`default_nettype wire

// ### verilog/pfs_apb_regs.sv
// APB register slave for the port sequencer: control staging and
// commit, setup, status readback and fault-clear strobe.
// Assumes an APB master on the same clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module pfs_apb_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] ctrl_act,
  output logic [7:0] setup_bits,
  output logic fault_clr,
  input wire logic [3:0] pg,
  input wire logic [3:0] shorted,
  input wire logic [3:0] opened,
  input wire logic [6:0] dev_addr
);
  pfs_pkg::regs_state_t r_r, r_nxt;

  // Address decode for the error flag; the read mux decodes paddr itself
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_CONTROL) || (a == `OFS_SETUP) ||
             (a == `OFS_STATUS1) || (a == `OFS_STATUS2) ||
             (a == `OFS_COMMIT) || (a == `OFS_ADDRESS);
  endfunction

  // Read data is captured in the setup phase so it leaves a flop
  always_comb begin
    r_nxt = r_r;
    fault_clr = 1'b0;
    if (psel && !penable) begin
      r_nxt.err = !mapped(paddr);
      r_nxt.rdata = `RDATA_RST;
      case (paddr)
        `OFS_CONTROL: r_nxt.rdata[7:0] = r_r.pend;
        `OFS_SETUP: r_nxt.rdata[7:0] = r_r.setup;
        `OFS_STATUS1: r_nxt.rdata[7:0] = {`STATUS1_RSVD, pg};
        `OFS_STATUS2: r_nxt.rdata[7:0] = {opened, shorted};
        `OFS_ADDRESS: r_nxt.rdata[6:0] = dev_addr;
        default: r_nxt.rdata = `RDATA_RST;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        `OFS_CONTROL: r_nxt.pend = pwdata[7:0];
        `OFS_SETUP: begin
          r_nxt.setup = pwdata[7:0] & `SU_STORE_MASK;
          fault_clr = pwdata[`SU_CLEAR];
        end
        // Staged enables act only at the end of the transaction
        `OFS_COMMIT: r_nxt.act = r_r.pend;
        default: r_nxt.act = r_r.act;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs; no wait states, so ready is constant
  assign prdata = r_r.rdata;
  assign pready = 1'b1;
  assign pslverr = r_r.err & psel & penable;
  assign ctrl_act = r_r.act;
  assign setup_bits = r_r.setup;
endmodule
`default_nettype wire

// ### tb/pfs_load_model.sv
// Far-side model: FETs, loads and sense comparators of four channels.
// Assumes gate drive from the sequencer; short/open loads set by bench.
`timescale 1ns/1ps
`default_nettype none
module pfs_load_model (
  input wire logic clk,
  input wire logic [3:0] gate,
  input wire logic [3:0] shorted_load,
  input wire logic [3:0] open_load,
  output logic [3:0] pgood,
  output logic [3:0] ilim,
  output logic [3:0] undercur
);
  // Known levels before the first edge
  initial begin
    pgood = 4'h0;
    ilim = 4'h0;
    undercur = 4'hF;
  end

  // One cycle of lag stands for the FET and output settling
  always @(posedge clk) begin
    pgood <= gate & ~shorted_load;
    ilim <= gate & shorted_load;
    undercur <= ~gate | open_load; // No current flows while the gate is off
  end
endmodule
`default_nettype wire

// ### tb/port_power_fault_sequencer_tb.sv
// Self-checking bench: APB host tasks plus the load model.
// Assumes pfs_map.svh on the include path, shortened timer parameters.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module port_power_fault_sequencer_tb;
  localparam int TON = 8;
  localparam int LIM = 4;
  localparam int GRD = 6;
  localparam int FILT = 8;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic fault_o, fault_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] straps;
  logic [3:0] pgood, ilim, undercur, relay, gate, short_ld, open_ld;
  logic [6:0] dev_addr;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  port_power_fault_sequencer #(.TON_CYC(TON), .FILT_CYC(FILT),
    .LIMIT_BASE_CYC(LIM), .GUARD_BASE_CYC(GRD)) DUT (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ADDR_STRAP(straps),
    .PGOOD_IN(pgood), .ILIM_IN(ilim), .UNDERCUR_IN(undercur),
    .RELAY_DRIVE(relay), .GATE_DRIVE(gate), .FAULT_N_O(fault_o),
    .FAULT_N_OE(fault_oe), .DEV_ADDR(dev_addr));

  pfs_load_model LOAD (.clk(clock), .gate(gate), .shorted_load(short_ld),
    .open_load(open_ld), .pgood(pgood), .ilim(ilim), .undercur(undercur));

  always #12.5 clock = ~clock;

  // Hang guard, far above the fewer than two thousand cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, hi, v);
    total_checks++;
    if (v < lo || v > hi) begin
      failures++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [7:0] d, output logic [31:0] q, output logic er);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge clock);
    penable <= 1'b1;
    // Ends once pready is sampled high; only the bench's hang guard bounds it
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 8'h00, q, er);
    chk(nm, e, q);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Edges until a channel's gate (gsel) or relay reaches a level
  task automatic wait_lvl(input logic gsel, input int ch, input logic lv,
    output int n);
    n = 0;
    #1;
    while ((gsel ? gate[ch] : relay[ch]) !== lv && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    // A level that never comes counts as a mismatch
    if (n == 2000) chk("level wait", 32'(lv), 32'(!lv));
  endtask

  task automatic t_addr();
    logic [31:0] q;
    logic er;
    chk("device address", 32'h0000_0036, 32'(dev_addr));
    rdchk("address reg", `OFS_ADDRESS, 32'h0000_0036);
    apb(1'b0, 12'h0F0, 8'h00, q, er);
    chk("unmapped error", 32'h0000_0001, 32'(er));
    chk("unmapped data", 32'h0000_0000, q);
  endtask

  task automatic t_power_on();
    int n;
    wr(`OFS_CONTROL, 8'h11);
    tick(3);
    chk("relay before commit", 32'h0000_0000, 32'(relay));
    wr(`OFS_COMMIT, 8'h00);
    #1;
    chk("relay at commit", 32'h0000_0000, 32'(relay[0]));
    tick(1);
    chk("relay after commit", 32'h0000_0001, 32'(relay[0]));
    chk("gate after commit", 32'h0000_0000, 32'(gate[0]));
    wait_lvl(1'b1, 0, 1'b1, n);
    chk("turn-on delay", 32'(TON), 32'(n));
    tick(3);
    rdchk("status1 on", `OFS_STATUS1, 32'h0000_0011);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_COMMIT, 8'h00);
    tick(2);
    chk("drives off", 32'h0000_0000, 32'({relay[0], gate[0]}));
    rdchk("status1 off", `OFS_STATUS1, 32'h0000_0010);
  endtask

  task automatic t_open();
    int n;
    @(posedge clock);
    open_ld <= 4'h2;
    wr(`OFS_SETUP, 8'h02);
    wr(`OFS_CONTROL, 8'h22);
    wr(`OFS_COMMIT, 8'h00);
    wait_lvl(1'b1, 1, 1'b1, n);
    tick(40);
    chk("open ignored", 32'h0000_0001, 32'(gate[1]));
    wr(`OFS_SETUP, 8'h06);
    wait_lvl(1'b1, 1, 1'b0, n);
    chk_rng("open filter", 7, 10, n);
    chk("pin on open", 32'h0000_0001, 32'(fault_oe));
    rdchk("status2 open", `OFS_STATUS2, 32'h0000_0020);
    tick(600);
    chk("open stays off", 32'h0000_0000, 32'(relay[1]));
    wr(`OFS_SETUP, 8'h07);
    tick(2);
    chk("pin released", 32'h0000_0000, 32'(fault_oe));
    rdchk("status2 cleared", `OFS_STATUS2, 32'h0000_0000);
    chk("open restart", 32'h0000_0001, 32'(relay[1]));
    wr(`OFS_SETUP, 8'h00);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_COMMIT, 8'h00);
  endtask

  // Guard and limit select fields, on the fourth channel
  task automatic t_select();
    int n;
    @(posedge clock);
    open_ld <= 4'hA;
    wr(`OFS_SETUP, 8'hC4);
    wr(`OFS_CONTROL, 8'h88);
    wr(`OFS_COMMIT, 8'h00);
    wait_lvl(1'b1, 3, 1'b1, n);
    wait_lvl(1'b1, 3, 1'b0, n);
    chk_rng("guard sel", GRD*8 + FILT, GRD*8 + FILT + 3, n);
    rdchk("status2 ch4 open", `OFS_STATUS2, 32'h0000_0080);
    @(posedge clock);
    open_ld <= 4'h2;
    short_ld <= 4'h8;
    wr(`OFS_SETUP, 8'h21);
    wait_lvl(1'b1, 3, 1'b1, n);
    wait_lvl(1'b1, 3, 1'b0, n);
    chk_rng("limit sel", LIM * 4, LIM * 4 + 2, n);
    @(posedge clock);
    short_ld <= 4'h0;
    wr(`OFS_SETUP, 8'h01);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_COMMIT, 8'h00);
  endtask

  // Persistent short: latch-off, early clear, then autoretry
  task automatic t_short();
    int n;
    @(posedge clock);
    short_ld <= 4'h4;
    wr(`OFS_SETUP, 8'h08);
    wr(`OFS_CONTROL, 8'h44);
    wr(`OFS_COMMIT, 8'h00);
    wait_lvl(1'b1, 2, 1'b1, n);
    wait_lvl(1'b1, 2, 1'b0, n);
    chk_rng("limit time", LIM - 1, LIM + 2, n);
    chk("pin on short", 32'h0000_0001, 32'(fault_oe));
    rdchk("status2 short", `OFS_STATUS2, 32'h0000_0004);
    tick(100);
    chk("latched off", 32'h0000_0000, 32'(relay[2]));
    wr(`OFS_SETUP, 8'h09);
    tick(2);
    chk("restart on clear", 32'h0000_0001, 32'(relay[2]));
    chk("pin cleared", 32'h0000_0000, 32'(fault_oe));
    wait_lvl(1'b1, 2, 1'b1, n);
    wait_lvl(1'b1, 2, 1'b0, n);
    wr(`OFS_SETUP, 8'h09);
    wait_lvl(1'b0, 2, 1'b1, n);
    chk_rng("retry high duty", 58, 68, n);
    wr(`OFS_SETUP, 8'h02);
    wait_lvl(1'b1, 2, 1'b1, n);
    wait_lvl(1'b1, 2, 1'b0, n);
    @(posedge clock);
    short_ld <= 4'h0;
    wait_lvl(1'b0, 2, 1'b1, n);
    chk_rng("retry low duty", 474, 484, n);
    wait_lvl(1'b1, 2, 1'b1, n);
    tick(3);
    rdchk("pg after retry", `OFS_STATUS1, 32'h0000_0014);
    rdchk("short kept", `OFS_STATUS2, 32'h0000_0004);
    chk("pin kept", 32'h0000_0001, 32'(fault_oe));
    chk("pin data low", 32'h0000_0000, 32'(fault_o));
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    straps = 5'h16;
    short_ld = 4'h0;
    open_ld = 4'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    tick(2);
    t_addr();
    t_power_on();
    t_open();
    t_select();
    t_short();
    finish_test();
  end
endmodule
`default_nettype wire
